// ===== hw/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

  // ----------------------------------------------------------------
  // Flash bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Command addresses and codes
  // ----------------------------------------------------------------
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h0_5555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h0_2AAA;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [7:0] CODE_QUERY_ENTRY = 8'h98;
  localparam logic [7:0] CODE_EXIT = 8'hF0;
  // Upper data byte is driven low during command writes
  localparam logic [7:0] UPPER_BYTE_FILL = 8'h00;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  localparam int SECTOR_LSB = 11;
  localparam int BLOCK_LSB = 15;

  // ----------------------------------------------------------------
  // Orders written into the command register
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h4;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
  localparam logic [3:0] OP_ID_ENTRY = 4'h6;
  localparam logic [3:0] OP_QUERY_ENTRY = 4'h7;
  localparam logic [3:0] OP_EXIT = 4'h8;
  localparam logic [3:0] OP_EXIT_LONG = 4'h9;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;

  // ----------------------------------------------------------------
  // Timing at 50 MHz
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_US = 40;
  localparam int PROGRAM_CYC = (PROGRAM_US * 1000) / CLK_NS;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } flash_pins_s;

endpackage : flash_ctrl_pkg

// ===== hw/flash_ctrl.sv
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Every word program is preceded by the three-write unlock.
// - Every erase uses the full six-write sequence.
// - Upper data byte driven to a valid level during commands.
// - Query entry is the unlock then 98H to 5555H.
// - Query mode stays until the exit command is written.
module flash_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);

  // ----------------------------------------------------------------
  // Sequencer state and registers
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SETUP = 6'b00_0010,
    ST_STROBE = 6'b00_0100,
    ST_RECOVER = 6'b00_1000,
    ST_POLL = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } seq_state_e;

  seq_state_e state_reg, state_next;
  flash_ctrl_pkg::flash_pins_s pins_reg;
  logic [18:0] addr_reg;
  logic [15:0] wdata_reg, rdata_reg;
  logic [3:0] op_reg;
  logic [2:0] step_reg, nsteps_reg;
  logic is_read_reg, poll_reg, have_prev_reg, busy_reg, err_reg;
  logic prev_tog_reg;
  logic tog_same_reg;
  logic [7:0] strobe_cnt_reg;
  logic [21:0] poll_cnt_reg;
  logic aw_held_reg, w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;

  // Step address/data of a command sequence
  function automatic logic [34:0] seq_word(input logic [3:0] op, input logic [2:0] s,
                                           input logic [18:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    if (op == flash_ctrl_pkg::OP_PROGRAM && s == 3'd3) return {a, d};
    if (s == 3'd0 || s == 3'd3) return {flash_ctrl_pkg::UNLOCK_ADDR1,
      flash_ctrl_pkg::UPPER_BYTE_FILL, flash_ctrl_pkg::CODE_UNLOCK1};
    if (s == 3'd1 || s == 3'd4) return {flash_ctrl_pkg::UNLOCK_ADDR2,
      flash_ctrl_pkg::UPPER_BYTE_FILL, flash_ctrl_pkg::CODE_UNLOCK2};
    case (op)
      flash_ctrl_pkg::OP_PROGRAM: c = flash_ctrl_pkg::CODE_PROGRAM;
      flash_ctrl_pkg::OP_ID_ENTRY: c = flash_ctrl_pkg::CODE_ID_ENTRY;
      flash_ctrl_pkg::OP_QUERY_ENTRY: c = flash_ctrl_pkg::CODE_QUERY_ENTRY;
      flash_ctrl_pkg::OP_EXIT_LONG: c = flash_ctrl_pkg::CODE_EXIT;
      default: c = flash_ctrl_pkg::CODE_ERASE_SETUP;
    endcase
    if (s == 3'd2) return {flash_ctrl_pkg::UNLOCK_ADDR1, flash_ctrl_pkg::UPPER_BYTE_FILL, c};
    if (op == flash_ctrl_pkg::OP_PROGRAM) return {a, d};
    case (op)
      flash_ctrl_pkg::OP_SECTOR_ERASE: return {a[18:flash_ctrl_pkg::SECTOR_LSB],
        11'h000, flash_ctrl_pkg::UPPER_BYTE_FILL, flash_ctrl_pkg::CODE_SECTOR_ERASE};
      flash_ctrl_pkg::OP_BLOCK_ERASE: return {a[18:flash_ctrl_pkg::BLOCK_LSB],
        15'h0000, flash_ctrl_pkg::UPPER_BYTE_FILL, flash_ctrl_pkg::CODE_BLOCK_ERASE};
      default: return {flash_ctrl_pkg::UNLOCK_ADDR1, flash_ctrl_pkg::UPPER_BYTE_FILL,
        flash_ctrl_pkg::CODE_CHIP_ERASE};
    endcase
  endfunction : seq_word

  // ----------------------------------------------------------------
  // AXI4-Lite slave decode
  // ----------------------------------------------------------------
  wire aw_ok = aw_held_reg || s_axi_awvalid;
  wire w_ok = w_held_reg || s_axi_wvalid;
  wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
  wire [3:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire wr_cmd = wr_fire && wr_addr == flash_ctrl_pkg::REG_CMD;
  wire [3:0] cmd_op = wr_data[3:0];
  wire cmd_legal = cmd_op >= flash_ctrl_pkg::OP_READ && cmd_op <= flash_ctrl_pkg::OP_EXIT_LONG;
  wire start = wr_cmd && !busy_reg && cmd_legal;
  wire wr_known = wr_addr == flash_ctrl_pkg::REG_ADDR || wr_addr == flash_ctrl_pkg::REG_WDATA
                  || wr_cmd;
  wire wr_bad = !wr_known || (wr_cmd && (busy_reg || !cmd_legal));
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire [31:0] rd_word =
    s_axi_araddr == flash_ctrl_pkg::REG_ADDR ? {13'h0000, addr_reg} :
    s_axi_araddr == flash_ctrl_pkg::REG_WDATA ? {16'h0000, rdata_reg} :
    s_axi_araddr == flash_ctrl_pkg::REG_CMD ? {28'h000_0000, op_reg} :
    {30'h0000_0000, err_reg, busy_reg};
  wire rd_bad = s_axi_araddr > flash_ctrl_pkg::REG_STATUS || s_axi_araddr[1:0] != 2'b00;

  // Bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flash_ctrl_pkg::AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= flash_ctrl_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire) aw_addr_reg <= s_axi_awaddr;
      if (s_axi_awvalid && s_axi_awready && !wr_fire) aw_held_reg <= 1'b1;
      if (s_axi_wvalid && s_axi_wready && !wr_fire) w_data_reg <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready && !wr_fire) w_held_reg <= 1'b1;
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? flash_ctrl_pkg::AXI_SLVERR : flash_ctrl_pkg::AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_bad ? 32'h0000_0000 : rd_word;
        s_axi_rresp <= rd_bad ? flash_ctrl_pkg::AXI_SLVERR : flash_ctrl_pkg::AXI_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash sequencer
  // ----------------------------------------------------------------
  wire strobe_done = strobe_cnt_reg == 8'(flash_ctrl_pkg::STROBE_CYC - 1);
  wire last_step = step_reg == nsteps_reg;
  // Step code 7 marks a status read, never a command step
  wire poll_step = step_reg == 3'd7;
  wire [34:0] word_now = seq_word(op_reg, step_reg, addr_reg, wdata_reg);
  wire cur_tog = flash_dq_i[flash_ctrl_pkg::TOGGLE_BIT];
  // two equal reads mean done
  // Judged at capture: the released bus holds nothing worth comparing
  wire tog_same = tog_same_reg;
  // Counter runs during strobes too, so an equality test could be skipped
  wire poll_timeout = poll_cnt_reg >= 22'(flash_ctrl_pkg::PROGRAM_CYC * 8);
  wire [2:0] op_steps =
    cmd_op == flash_ctrl_pkg::OP_READ || cmd_op == flash_ctrl_pkg::OP_EXIT ? 3'd0 :
    cmd_op == flash_ctrl_pkg::OP_PROGRAM ? 3'd3 :
    cmd_op >= flash_ctrl_pkg::OP_SECTOR_ERASE && cmd_op <= flash_ctrl_pkg::OP_CHIP_ERASE ? 3'd5 :
    3'd2;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start) state_next = ST_SETUP;
      ST_SETUP: state_next = ST_STROBE;
      ST_STROBE: if (strobe_done) state_next = ST_RECOVER;
      ST_RECOVER: if (strobe_done) state_next = !last_step && !poll_step ? ST_SETUP :
                      poll_reg ? ST_POLL : ST_DONE;
      ST_POLL: if (tog_same || poll_timeout) state_next = ST_DONE;
                  else state_next = ST_SETUP;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h0_0000,
                    dq_out: 16'h0000, dq_oe: 1'b0};
      addr_reg <= 19'h0_0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      op_reg <= 4'h0;
      step_reg <= 3'd0;
      nsteps_reg <= 3'd0;
      is_read_reg <= 1'b0;
      poll_reg <= 1'b0;
      have_prev_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
      tog_same_reg <= 1'b0;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      strobe_cnt_reg <= 8'h00;
      poll_cnt_reg <= 22'h00_0000;
    end else begin
      state_reg <= state_next;
      if (wr_fire && wr_addr == flash_ctrl_pkg::REG_ADDR && !busy_reg)
        addr_reg <= wr_data[18:0];
      if (wr_fire && wr_addr == flash_ctrl_pkg::REG_WDATA && !busy_reg)
        wdata_reg <= wr_data[15:0];
      if (state_reg == ST_STROBE || state_reg == ST_RECOVER)
        strobe_cnt_reg <= strobe_done ? 8'h00 : strobe_cnt_reg + 8'h01;
      if (busy_reg && poll_reg) poll_cnt_reg <= poll_cnt_reg + 22'h00_0001;
      case (state_reg)
        ST_IDLE: if (start) begin
          op_reg <= cmd_op;
          nsteps_reg <= op_steps;
          step_reg <= 3'd0;
          busy_reg <= 1'b1;
          err_reg <= 1'b0;
          poll_cnt_reg <= 22'h00_0000;
          have_prev_reg <= 1'b0;
          tog_same_reg <= 1'b0;
          poll_reg <= cmd_op >= flash_ctrl_pkg::OP_PROGRAM &&
                      cmd_op <= flash_ctrl_pkg::OP_CHIP_ERASE;
          is_read_reg <= cmd_op == flash_ctrl_pkg::OP_READ;
        end
        ST_SETUP: begin
          pins_reg.ce_n <= 1'b0;
          if (is_read_reg || state_reg == ST_SETUP && poll_reg && step_reg > nsteps_reg) begin
            pins_reg.addr <= addr_reg;
            pins_reg.dq_oe <= 1'b0;
          end else if (op_reg == flash_ctrl_pkg::OP_EXIT) begin
            pins_reg.addr <= flash_ctrl_pkg::UNLOCK_ADDR1;
            pins_reg.dq_out <= {flash_ctrl_pkg::UPPER_BYTE_FILL, flash_ctrl_pkg::CODE_EXIT};
            pins_reg.dq_oe <= 1'b1;
          end else begin
            pins_reg.addr <= word_now[34:16];
            pins_reg.dq_out <= word_now[15:0];
            pins_reg.dq_oe <= 1'b1;
          end
        end
        ST_STROBE: begin
          if (pins_reg.dq_oe) pins_reg.we_n <= 1'b0;
          else pins_reg.oe_n <= 1'b0;
        end
        ST_RECOVER: begin
          if (strobe_cnt_reg == 8'h00) begin
            pins_reg.we_n <= 1'b1;
            pins_reg.oe_n <= 1'b1;
          end
          if (strobe_cnt_reg == 8'h00 && !pins_reg.dq_oe) begin
            rdata_reg <= flash_dq_i;
            prev_tog_reg <= cur_tog;
            tog_same_reg <= have_prev_reg && cur_tog == prev_tog_reg;
            have_prev_reg <= 1'b1;
          end
          if (strobe_done) begin
            pins_reg.ce_n <= 1'b1;
            pins_reg.dq_oe <= 1'b0;
            if (!last_step && !poll_step) step_reg <= step_reg + 3'd1;
            if (last_step && poll_reg) step_reg <= 3'd7;
          end
        end
        ST_POLL: begin
          if (poll_timeout) err_reg <= 1'b1;
        end
        ST_DONE: busy_reg <= 1'b0;
        default: busy_reg <= 1'b0;
      endcase
    end
  end

  assign flash_ce_n = pins_reg.ce_n;
  assign flash_oe_n = pins_reg.oe_n;
  assign flash_we_n = pins_reg.we_n;
  assign flash_addr = pins_reg.addr;
  assign flash_dq_o = pins_reg.dq_out;
  assign flash_dq_oe = pins_reg.dq_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_low;
    !flash_we_n && !flash_ce_n;
  endsequence

  a_write_inhibit_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe)
    else $error("write strobe with bad enables");
  a_no_bus_fight: assert property (@(posedge aclk) disable iff (!aresetn)
    !flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data during read");
  a_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(flash_we_n) |-> s_write_low [*3])
    else $error("write strobe too short");
  a_upper_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_write_low and !(op_reg == flash_ctrl_pkg::OP_PROGRAM && step_reg == 3'd3)) |->
    flash_dq_o[15:8] == flash_ctrl_pkg::UPPER_BYTE_FILL)
    else $error("upper byte not driven low");
  a_data_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("data changed under strobe");
  a_first_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(flash_we_n) && step_reg == 3'd0 && op_reg != flash_ctrl_pkg::OP_EXIT |->
    flash_addr == flash_ctrl_pkg::UNLOCK_ADDR1 && flash_dq_o[7:0] == 8'hAA)
    else $error("sequence without unlock");
  a_deselect_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_IDLE |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("flash selected while idle");
  a_busy_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_reg && wr_cmd |=> s_axi_bresp == flash_ctrl_pkg::AXI_SLVERR)
    else $error("command accepted while busy");

endmodule : flash_ctrl

// ===== tb/flash_mem_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Behavioural parallel flash
// ------------------------------------------------------------
module flash_mem_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0A5C, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1C3E, // Arbitrary value
  parameter int BUSY_READS = 5
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [15:0] rd_word = 16'h0000;
  logic [15:0] last_d = 16'hFFFF;
  logic [18:0] a_lat = 19'h0_0000;
  logic [18:0] erase_addr = 19'h0_0000;
  logic [7:0] erase_code = 8'h00;
  logic toggle = 1'b0;
  int step = 0;
  int busy = 0;
  int mode = 0; // 0 array, 1 ident, 2 query
  int prog_cnt = 0;
  int erase_cnt = 0;
  int bad_cnt = 0;
  realtime t_fall = 0;

  // One accepted bus write against the command sequence
  task automatic take(input logic [18:0] a, input logic [15:0] d);
    logic hit1;
    logic hit2;
    hit1 = (a[14:0] == 15'h5555);
    hit2 = (a[14:0] == 15'h2AAA);
    if ($isunknown(d[15:8])) bad_cnt++;
    if (busy > 0) return;
    if (step == 3) begin
      mem[a] = d;
      last_d = d;
      prog_cnt++;
      busy = BUSY_READS;
      step = 0;
      return;
    end
    if (d[7:0] == 8'hF0 && (step == 0 || step == 2)) begin
      mode = 0;
      step = 0;
      return;
    end
    case (step)
      0, 4: step = (hit1 && d[7:0] == 8'hAA) ? step + 1 : 0;
      1, 5: step = (hit2 && d[7:0] == 8'h55) ? step + 1 : 0;
      2: begin
        step = 0;
        // entry codes at the first unlock address
        if (hit1 && d[7:0] == 8'hA0) step = 3;
        if (hit1 && d[7:0] == 8'h80) step = 4;
        if (hit1 && d[7:0] == 8'h90) mode = 1;
        if (hit1 && d[7:0] == 8'h98) mode = 2;
      end
      default: begin
        step = 0;
        if (d[7:0] inside {8'h30, 8'h50} || (d[7:0] == 8'h10 && hit1)) begin
          erase_cnt++;
          erase_addr = a;
          erase_code = d[7:0];
          last_d = 16'hFFFF;
          busy = BUSY_READS;
          if (d[7:0] == 8'h10) mem.delete();
        end
      end
    endcase
  endtask : take

  // Address latched on the falling strobe
  always @(negedge we_n) begin
    a_lat = addr;
    t_fall = $realtime;
  end

  always @(posedge we_n) begin
    if (!ce_n && !oe_n) bad_cnt++;
    if (!ce_n && oe_n && $realtime - t_fall >= 5.0) take(a_lat, dq_in);
  end

  always @(negedge oe_n) begin
    if (busy > 0) rd_word = {8'h00, ~last_d[7], toggle, 6'h00};
    else if (mode == 1) rd_word = addr[0] ? PART_CODE : MAKER_CODE;
    else if (mode == 2 && addr == 19'h0_0010) rd_word = 16'h0051;
    else rd_word = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end

  always @(posedge oe_n) begin
    if (busy > 0) begin
      toggle = ~toggle;
      busy--;
    end
  end

  // released lines show a changed pattern
  assign dq_out = (!ce_n && !oe_n && we_n) ? rd_word : ~rd_word;
endmodule : flash_mem_model

// ===== tb/tb_flash_ctrl.sv
`timescale 1ns/10ps
module tb_flash_ctrl;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [18:0] faddr;
  logic [15:0] dq_o, dq_i;
  int failures = 0, checked = 0, cycles = 0;

  // Clock and cycle ceiling
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      give_verdict();
    end
  end

  flash_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  flash_mem_model u_mem (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
    .dq_in(dq_o), .dq_out(dq_i));

  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Order a flash operation and poll until idle
  task automatic run_cmd(input logic [3:0] op);
    axi_wr(flash_ctrl_pkg::REG_CMD, {28'h000_0000, op}, resp);
    check({30'h0, resp}, {30'h0, flash_ctrl_pkg::AXI_OKAY}, "cmd resp");
    do axi_rd(flash_ctrl_pkg::REG_STATUS, rd, resp); while (rd[0] !== 1'b0);
    check(rd, 32'h0000_0000, "status after op");
  endtask : run_cmd

  task automatic read_at(input logic [18:0] a, input logic [15:0] exp);
    axi_wr(flash_ctrl_pkg::REG_ADDR, {13'h0000, a}, resp);
    run_cmd(flash_ctrl_pkg::OP_READ);
    axi_rd(flash_ctrl_pkg::REG_WDATA, rd, resp);
    check({30'h0, resp}, {30'h0, flash_ctrl_pkg::AXI_OKAY}, "read resp");
    check({16'h0000, rd[15:0]}, {16'h0000, exp}, "flash word");
  endtask : read_at

  logic [3:0] eops [3] = '{4'h3, 4'h4, 4'h5};
  logic [7:0] ecode [3] = '{8'h30, 8'h50, 8'h10};
  logic [18:0] eaddr [2] = '{19'h7_F800, 19'h7_8000};
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(flash_ctrl_pkg::REG_STATUS, rd, resp);
    check(rd, 32'h0000_0000, "status reset");
    axi_wr(flash_ctrl_pkg::REG_ADDR, 32'h0000_1234, resp);
    axi_wr(flash_ctrl_pkg::REG_WDATA, 32'h0000_BEEF, resp);
    run_cmd(flash_ctrl_pkg::OP_PROGRAM);
    check(u_mem.prog_cnt, 1, "programs");
    check(u_mem.busy, 0, "device idle at done");
    read_at(19'h0_1234, 16'hBEEF);
    // Refused orders leave the device untouched
    axi_wr(flash_ctrl_pkg::REG_CMD, 32'h0000_0000, resp);
    check({30'h0, resp}, {30'h0, flash_ctrl_pkg::AXI_SLVERR}, "bad code");
    axi_rd(4'h2, rd, resp);
    check({30'h0, resp}, {30'h0, flash_ctrl_pkg::AXI_SLVERR}, "unmapped read");
    check(rd, 32'h0000_0000, "unmapped data");
    axi_wr(flash_ctrl_pkg::REG_CMD, 32'h0000_0002, resp);
    axi_wr(flash_ctrl_pkg::REG_CMD, 32'h0000_0002, resp);
    check({30'h0, resp}, {30'h0, flash_ctrl_pkg::AXI_SLVERR}, "cmd while busy");
    do axi_rd(flash_ctrl_pkg::REG_STATUS, rd, resp); while (rd[0] !== 1'b0);
    run_cmd(flash_ctrl_pkg::OP_READ);
    check(u_mem.prog_cnt, 2, "one program only");
    for (int i = 0; i < 3; i++) begin
      axi_wr(flash_ctrl_pkg::REG_ADDR, 32'h0007_FFFF, resp);
      run_cmd(eops[i]);
      check({24'h0, u_mem.erase_code}, {24'h0, ecode[i]}, "erase code");
      if (i < 2) check({13'h0, u_mem.erase_addr}, {13'h0, eaddr[i]}, "erase addr");
    end
    check(u_mem.erase_cnt, 3, "erases");
    read_at(19'h0_1234, 16'hFFFF);
    run_cmd(flash_ctrl_pkg::OP_ID_ENTRY);
    read_at(19'h0_0000, u_mem.MAKER_CODE);
    read_at(19'h0_0001, u_mem.PART_CODE);
    run_cmd(flash_ctrl_pkg::OP_EXIT);
    read_at(19'h0_0001, 16'hFFFF);
    run_cmd(flash_ctrl_pkg::OP_QUERY_ENTRY);
    read_at(19'h0_0010, 16'h0051);
    read_at(19'h0_0010, 16'h0051);
    run_cmd(flash_ctrl_pkg::OP_EXIT_LONG);
    read_at(19'h0_0010, 16'hFFFF);
    check(u_mem.bad_cnt, 0, "strobe and upper byte faults");
    give_verdict();
  end
endmodule : tb_flash_ctrl
